/* File: dv/dhrs_nvm_model.sv */
// Settings storage model for the reset sequencer
`timescale 1ns/1ps
module dhrs_nvm_model (
  input  wire logic       i_clk,
  input  wire logic       i_rd,
  input  wire logic [3:0] i_addr,
  output logic      [7:0] o_data
);
  initial o_data = 8'h00;
  always @(posedge i_clk) o_data <= i_rd ? {~i_addr, i_addr} : ~o_data;
endmodule

/* File: dv/dhrs_seq_properties.sv */
// Port checker for the reset sequencer
`timescale 1ns/1ps
module dhrs_seq_chk (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_hw_reset_in_n,
  input wire logic       i_sleep_out,
  input wire logic [7:0] i_nvm_data,
  input wire logic       o_blank,
  input wire logic       o_busy,
  input wire logic       o_regs_default,
  input wire logic       o_nvm_rd,
  input wire logic [3:0] o_nvm_addr,
  input wire logic       o_load_done,
  input wire logic [7:0] o_common_electrode_setting
);
  logic [10:0] lo_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Consecutive low cycles on the pin
  always_ff @(posedge i_clk)
    if (i_rst || i_hw_reset_in_n) lo_q <= 11'h000;
    else if (lo_q != 11'h7FF) lo_q <= lo_q + 11'h001;
  sequence s_last_rd; o_nvm_rd && o_nvm_addr == 4'hF; endsequence
  AST_ACCEPT: assert property ($rose(o_regs_default) |-> lo_q >= 11'h3DE)
    else $error("reset taken too early");
  AST_HELD_BLANK: assert property (o_regs_default |-> o_blank && o_busy)
    else $error("held without blank");
  AST_LOAD_START: assert property (o_nvm_rd && o_nvm_addr == 4'h0 |-> $past(o_regs_default, 3))
    else $error("load not after release");
  AST_LOAD_ORDER: assert property (o_nvm_rd && o_nvm_addr != 4'hF |=> o_nvm_rd && o_nvm_addr == $past(o_nvm_addr) + 4'h1)
    else $error("read order broken");
  AST_DONE_AFTER: assert property (s_last_rd |-> ##[1:3] o_load_done)
    else $error("load done missing");
  AST_DONE_PULSE: assert property (o_load_done |=> !o_load_done)
    else $error("done not a pulse");
  AST_DEFAULT_CLEAR: assert property (o_regs_default |-> ##2 o_common_electrode_setting == 8'h00)
    else $error("setting not back to default");
  AST_SLEEPIN_END: assert property (o_load_done && !i_sleep_out |=> !o_busy && !o_blank)
    else $error("sleep-in reset not ended");
  AST_SLEEPOUT_HOLD: assert property (o_load_done && i_sleep_out |=> o_blank && o_busy)
    else $error("sleep-out blank cut short");
endmodule
bind dhrs_seq dhrs_seq_chk dhrs_seq_chk_inst (.*);

/* File: dv/dhrs_seq_tb_top.sv */
// Testbench for the reset sequencer
`timescale 1ns/1ps
module dhrs_seq_tb_top;
  logic       i_clk, i_rst, pin, sleep_out, blank, busy, dflt, rd, done;
  logic [7:0] nvm, ce;
  logic [3:0] addr;
  logic [7:0] exp_q[$];
  int         n_fail, n_compared;
  dhrs_seq dhrs_seq_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_hw_reset_in_n(pin), .i_sleep_out(sleep_out), .i_nvm_data(nvm),
    .o_blank(blank), .o_busy(busy), .o_regs_default(dflt), .o_nvm_rd(rd),
    .o_nvm_addr(addr), .o_load_done(done), .o_common_electrode_setting(ce));
  dhrs_nvm_model dhrs_nvm_model_inst (.i_clk(i_clk), .i_rd(rd),
    .i_addr(addr), .o_data(nvm));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Low pulse with an optional high glitch in the middle
  task automatic pulse(input int lo, input int gl);
    pin = 1'b0;
    repeat (lo / 2) @(negedge i_clk);
    if (gl != 0) begin
      pin = 1'b1;
      repeat (gl) @(negedge i_clk);
      pin = 1'b0;
    end
    repeat (lo / 2) @(negedge i_clk);
    pin = 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Scoreboard on each load completion
  always @(negedge i_clk) begin
    if (done === 1'b1) begin
      if (exp_q.size() != 0) check(ce, exp_q.pop_front());
      else check({7'h00, done}, 8'h00);
    end
  end
  initial begin
    #200us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    i_rst = 1'b1;
    pin = 1'b1;
    sleep_out = 1'b0;
    n_fail = 0;
    n_compared = 0;
    void'($urandom(56717));
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    pulse(100 + $urandom % 800, 0);
    repeat (1100) @(negedge i_clk);
    check({7'h00, busy}, 8'h00);
    for (int s = 0; s < 2; s++) begin
      // Mode stands for the state held before this reset
      sleep_out = s[0];
      exp_q.push_back(8'hC3);
      pulse(2100 + $urandom % 1000, 1 + $urandom % 500);
      check({6'h00, busy, dflt}, 8'h03);
      // No command is issued after a release
      for (int k = 0; k < 1200 && done !== 1'b1; k++) @(negedge i_clk);
      repeat (2) @(negedge i_clk);
      check({6'h00, blank, dflt}, {6'h00, s[0], 1'b0});
    end
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule

/* File: hw/dhrs_seq.sv */
// Hardware reset filter, blanking and settings load sequencer
`timescale 1ns/1ps
`include "dhrs_map.svh"
//////////////////////////////////////////////////////////////////////////////
// Function
// - Low pulses under 5 us are ignored and pulses of 9 us give reset.
// - Glitches high inside a held reset do not end or restart it.
// - After each release, settings are loaded from storage within 5 ms.
// - Reset completes within 5 ms from sleep-in, 120 ms from sleep-out.
// - The display is blanked while reset runs, blank sequence <=120 ms.
// - While reset is held the settings image returns to its reset default.
//////////////////////////////////////////////////////////////////////////////
module dhrs_seq (
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_hw_reset_in_n,
  input  wire logic                    i_sleep_out,
  input  wire logic [`DHRS_DATA_W-1:0] i_nvm_data,
  output logic                         o_blank,
  output logic                         o_busy,
  output logic                         o_regs_default,
  output logic                         o_nvm_rd,
  output logic [`DHRS_NVM_AW-1:0]      o_nvm_addr,
  output logic                         o_load_done,
  output logic [`DHRS_DATA_W-1:0]      o_common_electrode_setting
);

  localparam logic [`DHRS_CNT_W-1:0] REJ_C =
    `DHRS_CNT_W'(`DHRS_ACCEPT_CYC);
  localparam logic [`DHRS_CNT_W-1:0] BLK_C =
    `DHRS_CNT_W'(`DHRS_BLANK_CYC - `DHRS_LOAD_CYC);
  localparam logic [`DHRS_CNT_W-1:0] GLT_C =
    `DHRS_CNT_W'(`DHRS_REJECT_CYC);

  // Settings image held on chip, filled from storage
  logic [`DHRS_DATA_W-1:0] nvm_img_q [`DHRS_NVM_WORDS];

  dhrs_pkg::dhrs_state_t   st_q, st_d;
  logic [2:0]              sync_q;
  logic                    pin_q;
  logic [`DHRS_CNT_W-1:0]  lo_cnt_q, hi_cnt_q, tm_q;
  logic [`DHRS_NVM_AW-1:0] addr_q;
  logic                    rd_q, last_rd_q;
  logic                    mode_out_q;

  //////////////////////////////////////////////////////////////////////////
  // three-stage pin sync
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_q <= 3'h7;
      pin_q  <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], i_hw_reset_in_n};
      if (sync_q[2] == sync_q[1]) begin
        pin_q <= sync_q[2];
      end
    end
  end

  // Pulse width decode
  // Pin decodes use the filtered pin level; nvm_last and tm_done decode addr_q and tm_q
  wire pin_low    = ~pin_q;
  wire low_valid  = (lo_cnt_q >= REJ_C);
  wire hi_real    = (hi_cnt_q >= GLT_C);
  wire nvm_last   = (addr_q == `DHRS_NVM_LAST);
  wire tm_done    = (tm_q == '0);

  //////////////////////////////////////////////////////////////////////////
  // low width counter
  // A high gap must outlast the glitch filter to clear the count
  always_ff @(posedge i_clk) begin
    if (i_rst || (pin_q && hi_real)) begin
      lo_cnt_q <= '0;
    end else if (pin_low && !low_valid) begin
      lo_cnt_q <= lo_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || pin_low) begin
      hi_cnt_q <= '0;
    end else if (!hi_real) begin
      hi_cnt_q <= hi_cnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  // Stray codes fall back to running through the default branch
  always_comb begin
    st_d = st_q;
    case (st_q)
      dhrs_pkg::DHRS_RUN: begin
        if (low_valid) begin
          st_d = dhrs_pkg::DHRS_HELD;
        end
      end
      dhrs_pkg::DHRS_HELD: begin
        if (pin_q && hi_real) begin
          st_d = dhrs_pkg::DHRS_LOAD;
        end
      end
      dhrs_pkg::DHRS_LOAD: begin
        if (low_valid) begin
          st_d = dhrs_pkg::DHRS_HELD;
        end else if (last_rd_q) begin
          st_d = mode_out_q ? dhrs_pkg::DHRS_BLANK : dhrs_pkg::DHRS_RUN;
        end
      end
      dhrs_pkg::DHRS_BLANK: begin
        if (low_valid) begin
          st_d = dhrs_pkg::DHRS_HELD;
        end else if (tm_done) begin
          st_d = dhrs_pkg::DHRS_RUN;
        end
      end
      default: st_d = dhrs_pkg::DHRS_RUN;
    endcase
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= dhrs_pkg::DHRS_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // mode at reset start picks the completion path
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_out_q <= 1'b0;
    end else if (st_q == dhrs_pkg::DHRS_RUN) begin
      mode_out_q <= i_sleep_out;
    end
  end

  // blanking sequence timer
  // Reloads outside blanking so each run starts full
  always_ff @(posedge i_clk) begin
    if (i_rst || st_q != dhrs_pkg::DHRS_BLANK) begin
      tm_q <= BLK_C;
    end else if (!tm_done) begin
      tm_q <= tm_q - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // storage read walk
  wire in_load = (st_q == dhrs_pkg::DHRS_LOAD);
  always_ff @(posedge i_clk) begin
    if (i_rst || !in_load) begin
      addr_q    <= '0;
      rd_q      <= 1'b0;
      last_rd_q <= 1'b0;
    end else begin
      rd_q      <= !last_rd_q && !(rd_q && nvm_last);
      last_rd_q <= rd_q && nvm_last;
      if (rd_q && !nvm_last) begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // Capture each word the cycle after its read strobe
  // Storage answers one cycle after the strobe leaves the pins
  logic                    cap_q;
  logic [`DHRS_NVM_AW-1:0] cap_a_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_q   <= 1'b0;
      cap_a_q <= '0;
    end else begin
      cap_q   <= o_nvm_rd;
      cap_a_q <= o_nvm_addr;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DHRS_NVM_WORDS; gi++) begin : g_img
      // image back to default on reset
      always_ff @(posedge i_clk) begin
        if (i_rst || st_q == dhrs_pkg::DHRS_HELD) begin
          nvm_img_q[gi] <= '0;
        end else if (cap_q && cap_a_q == `DHRS_NVM_AW'(gi)) begin
          nvm_img_q[gi] <= i_nvm_data;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  // Blank and busy share one source so they never part
  wire busy_d = (st_d != dhrs_pkg::DHRS_RUN);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_blank        <= 1'b1;
      o_busy         <= 1'b1;
      o_regs_default <= 1'b1;
      o_nvm_rd       <= 1'b0;
      o_nvm_addr     <= '0;
      o_load_done    <= 1'b0;
      o_common_electrode_setting <= '0;
    end else begin
      o_blank        <= busy_d;
      o_busy         <= busy_d;
      o_regs_default <= (st_d == dhrs_pkg::DHRS_HELD);
      o_nvm_rd       <= rd_q;
      o_nvm_addr     <= addr_q;
      o_load_done    <= last_rd_q;
      o_common_electrode_setting <= nvm_img_q[`DHRS_NVM_COM_IDX];
    end
  end

endmodule

/* File: pkg/dhrs_map.svh */
// Timing and field constants for the display hardware reset sequencer
`ifndef DHRS_MAP_SVH
`define DHRS_MAP_SVH
`define DHRS_CLK_MHZ        200
`define DHRS_REJECT_US      5
`define DHRS_FULL_US        9
`define DHRS_LOAD_MS        5
`define DHRS_BLANK_MS       120
`define DHRS_REJECT_CYC     (`DHRS_REJECT_US * `DHRS_CLK_MHZ)
`define DHRS_FULL_CYC       (`DHRS_FULL_US * `DHRS_CLK_MHZ)
`define DHRS_LOAD_CYC       (`DHRS_LOAD_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_BLANK_CYC      (`DHRS_BLANK_MS * 1000 * `DHRS_CLK_MHZ)
`define DHRS_ACCEPT_CYC     (`DHRS_REJECT_CYC + 1)
`define DHRS_CNT_W          25
`define DHRS_NVM_AW         4
`define DHRS_NVM_WORDS      16
`define DHRS_NVM_LAST       4'hF
`define DHRS_NVM_COM_IDX    4'h3
`define DHRS_DATA_W         8
`endif

/* File: pkg/dhrs_pkg.sv */
// Types for the display hardware reset sequencer
package dhrs_pkg;
  typedef enum logic [2:0] {
    DHRS_RUN    = 3'b000,
    DHRS_HELD   = 3'b001,
    DHRS_BLANK  = 3'b010,
    DHRS_WAIT   = 3'b011,
    DHRS_LOAD   = 3'b100
  } dhrs_state_t;
endpackage
